// ### design/anp_pkg.sv
// Constants shared by the partner next page status registers.
package anp_pkg;
	localparam logic [4:0] DEVICE_ADDR = 5'h07;
	localparam logic [15:0] OFFSET_WORD1 = 16'h0019;
	localparam logic [15:0] OFFSET_WORD2 = 16'h001a;
	localparam logic [15:0] OFFSET_WORD3 = 16'h001b;
	localparam logic [15:0] OFFSET_RESULT = 16'h0030;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [15:0] RESET_RESULT = 16'h0001;
	localparam logic [47:0] RESET_PAGE = 48'h000000000000;
	localparam int POS_MORE_PAGES = 15;
	localparam int POS_PAGE_ACK = 14;
	localparam int POS_MESSAGE_PAGE = 13;
	localparam int POS_SECOND_ACK = 12;
	localparam int POS_TOGGLE = 11;
	localparam int POS_SHORT_CODE_HI = 10;
	localparam int POS_10G_WITH_FEC = 4;
	localparam int POS_10G = 3;
	localparam int POS_1G = 1;
	localparam int POS_ABILITY = 0;
	localparam int PAGE_LOW_HI = 15;
	localparam int PAGE_MID_LO = 16;
	localparam int PAGE_MID_HI = 31;
	localparam int PAGE_UP_LO = 32;
	localparam int PAGE_UP_HI = 47;
endpackage

// ### design/anp_page_store.sv
// Holds the last extended next page received from the link partner.
`timescale 1ns/1ns
module anp_page_store (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_page_valid,
	input wire logic [47:0] i_page,
	output logic [47:0] o_page
);
	typedef struct packed {
		logic [47:0] page;
	} anp_store_s;

	anp_store_s state;
	anp_store_s next_state;

	always_comb begin
		next_state = state;
		if (i_page_valid) begin
			next_state.page = i_page;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state.page <= anp_pkg::RESET_PAGE;
		end else begin
			state <= next_state;
		end
	end

	assign o_page = state.page;
endmodule

// ### design/anp_status_regs.sv
// Read-only management registers reporting the partner next page and the resolved mode.
`timescale 1ns/1ns
module anp_status_regs (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_page_valid,
	input wire logic [47:0] i_page,
	input wire logic i_resolved_10g_with_fec,
	input wire logic i_resolved_10g_backplane,
	input wire logic i_resolved_1g_backplane,
	input wire logic [4:0] i_mgmt_devad,
	input wire logic [15:0] i_mgmt_regad,
	input wire logic i_mgmt_rd,
	input wire logic i_mgmt_wr,
	input wire logic [15:0] i_mgmt_wdata,
	output logic [15:0] o_mgmt_rdata,
	output logic o_mgmt_rvalid
);
	typedef struct packed {
		logic [15:0] hold_middle;
		logic [15:0] hold_upper;
		logic [2:0] resolved;
		logic [15:0] rdata;
		logic rvalid;
	} anp_regs_s;

	anp_regs_s state;
	anp_regs_s next_state;
	logic [47:0] page;
	logic sel;
	logic [15:0] result_word;

	anp_page_store u_store (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_page_valid(i_page_valid),
		.i_page(i_page),
		.o_page(page)
	);

	function automatic logic hit(input logic [15:0] regad, input logic [15:0] offset);
		hit = (regad == offset);
	endfunction

	assign sel = i_mgmt_rd && (i_mgmt_devad == anp_pkg::DEVICE_ADDR);

	always_comb begin
		result_word = 16'h0000;
		result_word[anp_pkg::POS_10G_WITH_FEC] = state.resolved[2];
		result_word[anp_pkg::POS_10G] = state.resolved[1];
		result_word[anp_pkg::POS_1G] = state.resolved[0];
		result_word[anp_pkg::POS_ABILITY] = anp_pkg::RESET_RESULT[anp_pkg::POS_ABILITY];
	end

	// Only a read selects a register; no field has any write path.
	always_comb begin
		next_state = state;
		next_state.rvalid = sel;
		next_state.resolved = {i_resolved_10g_with_fec, i_resolved_10g_backplane,
			i_resolved_1g_backplane};
		if (sel) begin
			if (hit(i_mgmt_regad, anp_pkg::OFFSET_WORD1)) begin
				next_state.rdata = page[anp_pkg::PAGE_LOW_HI:0];
				next_state.hold_middle = page[anp_pkg::PAGE_MID_HI:anp_pkg::PAGE_MID_LO];
				next_state.hold_upper = page[anp_pkg::PAGE_UP_HI:anp_pkg::PAGE_UP_LO];
			end else if (hit(i_mgmt_regad, anp_pkg::OFFSET_WORD2)) begin
				next_state.rdata = state.hold_middle;
			end else if (hit(i_mgmt_regad, anp_pkg::OFFSET_WORD3)) begin
				next_state.rdata = state.hold_upper;
			end else if (hit(i_mgmt_regad, anp_pkg::OFFSET_RESULT)) begin
				next_state.rdata = result_word;
			end else begin
				next_state.rdata = 16'h0000;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state.hold_middle <= anp_pkg::RESET_WORD;
			state.hold_upper <= anp_pkg::RESET_WORD;
			state.resolved <= 3'h0;
			state.rdata <= anp_pkg::RESET_WORD;
			state.rvalid <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign o_mgmt_rdata = state.rdata;
	assign o_mgmt_rvalid = state.rvalid;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_nrst);

	a_word1_more_pages: assert property (
		sel && hit(i_mgmt_regad, anp_pkg::OFFSET_WORD1) |=>
		o_mgmt_rvalid && o_mgmt_rdata[anp_pkg::POS_MORE_PAGES] == $past(page[15]))
		else $error("Word one bit 15 differs from page D15.");
	a_word1_page_ack: assert property (
		sel && hit(i_mgmt_regad, anp_pkg::OFFSET_WORD1) |=>
		o_mgmt_rdata[anp_pkg::POS_PAGE_ACK] == $past(page[14]))
		else $error("Word one bit 14 differs from page D14.");
	a_word1_message_flag: assert property (
		sel && hit(i_mgmt_regad, anp_pkg::OFFSET_WORD1) |=>
		o_mgmt_rdata[anp_pkg::POS_MESSAGE_PAGE] == $past(page[13]))
		else $error("Word one bit 13 differs from page D13.");
	a_word1_second_ack: assert property (
		sel && hit(i_mgmt_regad, anp_pkg::OFFSET_WORD1) |=>
		o_mgmt_rdata[anp_pkg::POS_SECOND_ACK] == $past(page[12]))
		else $error("Word one bit 12 differs from page D12.");
	a_word1_toggle: assert property (
		sel && hit(i_mgmt_regad, anp_pkg::OFFSET_WORD1) |=>
		o_mgmt_rdata[anp_pkg::POS_TOGGLE] == $past(page[11]))
		else $error("Word one bit 11 differs from page D11.");
	a_word1_code_field: assert property (
		sel && hit(i_mgmt_regad, anp_pkg::OFFSET_WORD1) |=>
		o_mgmt_rdata[anp_pkg::POS_SHORT_CODE_HI:0] == $past(page[10:0]))
		else $error("Word one code field differs from page D10 to D0.");
	a_word2_coherent: assert property (
		sel && hit(i_mgmt_regad, anp_pkg::OFFSET_WORD1) ##1
		(sel && hit(i_mgmt_regad, anp_pkg::OFFSET_WORD2)) |=>
		o_mgmt_rdata == $past(page[31:16], 2))
		else $error("Word two does not match the page snapshot.");
	a_word3_coherent: assert property (
		sel && hit(i_mgmt_regad, anp_pkg::OFFSET_WORD1) ##1
		(sel && hit(i_mgmt_regad, anp_pkg::OFFSET_WORD3)) |=>
		o_mgmt_rdata == $past(page[47:32], 2))
		else $error("Word three does not match the page snapshot.");
	a_snapshot_stable: assert property (
		!(sel && hit(i_mgmt_regad, anp_pkg::OFFSET_WORD1)) |=>
		$stable(state.hold_middle) && $stable(state.hold_upper))
		else $error("Snapshot changed without a word one read.");
	a_result_bits: assert property (
		sel && hit(i_mgmt_regad, anp_pkg::OFFSET_RESULT) |=>
		o_mgmt_rdata[4:0] == {$past(i_resolved_10g_with_fec, 2),
			$past(i_resolved_10g_backplane, 2), 1'b0, $past(i_resolved_1g_backplane, 2), 1'b1})
		else $error("Result register does not show the resolved mode.");
	a_ability_one: assert property (
		sel && hit(i_mgmt_regad, anp_pkg::OFFSET_RESULT) |=>
		o_mgmt_rdata[anp_pkg::POS_ABILITY] && o_mgmt_rdata[15:5] == 11'h000)
		else $error("Ability bit is not one.");
	a_write_ignored: assert property (
		i_mgmt_wr && !sel |=> $stable(o_mgmt_rdata) && !o_mgmt_rvalid)
		else $error("A write changed the read data.");

	a_read_answered: assert property (
		sel |=>
		o_mgmt_rvalid)
		else $error("A read of this device got no answer.");
	a_answer_once: assert property (
		o_mgmt_rvalid |->
		$past(sel))
		else $error("An answer appeared without a read.");
	a_no_stray_answer: assert property (
		!sel |=>
		!o_mgmt_rvalid)
		else $error("An answer followed a cycle without a read.");
	a_other_device_quiet: assert property (
		i_mgmt_rd && (i_mgmt_devad != anp_pkg::DEVICE_ADDR) |=>
		!o_mgmt_rvalid)
		else $error("A read of another device was answered.");
	a_other_device_data: assert property (
		i_mgmt_rd && (i_mgmt_devad != anp_pkg::DEVICE_ADDR) |=>
		$stable(o_mgmt_rdata))
		else $error("A read of another device changed the read data.");
	a_unmapped_zero: assert property (
		sel && !hit(i_mgmt_regad, anp_pkg::OFFSET_WORD1) && !hit(i_mgmt_regad, anp_pkg::OFFSET_WORD2)
		&& !hit(i_mgmt_regad, anp_pkg::OFFSET_WORD3) && !hit(i_mgmt_regad, anp_pkg::OFFSET_RESULT) |=>
		o_mgmt_rdata == anp_pkg::RESET_WORD)
		else $error("An unmapped register did not read zero.");
	a_write_data_dropped: assert property (
		i_mgmt_wr && !sel && (i_mgmt_wdata != o_mgmt_rdata) |=>
		o_mgmt_rdata != $past(i_mgmt_wdata))
		else $error("Write data reached the read data.");
	a_page_capture: assert property (
		i_page_valid |=>
		page == $past(i_page))
		else $error("A received page was not stored.");
	a_page_hold: assert property (
		!i_page_valid |=>
		$stable(page))
		else $error("The stored page changed without a delivery.");
	a_snapshot_middle: assert property (
		sel && hit(i_mgmt_regad, anp_pkg::OFFSET_WORD1) |=>
		state.hold_middle == $past(page[31:16]))
		else $error("Word one read did not capture page D31 to D16.");
	a_snapshot_upper: assert property (
		sel && hit(i_mgmt_regad, anp_pkg::OFFSET_WORD1) |=>
		state.hold_upper == $past(page[47:32]))
		else $error("Word one read did not capture page D47 to D32.");
	a_word2_from_hold: assert property (
		sel && hit(i_mgmt_regad, anp_pkg::OFFSET_WORD2) |=>
		o_mgmt_rdata == $past(state.hold_middle))
		else $error("Word two did not return the captured middle word.");
	a_word3_from_hold: assert property (
		sel && hit(i_mgmt_regad, anp_pkg::OFFSET_WORD3) |=>
		o_mgmt_rdata == $past(state.hold_upper))
		else $error("Word three did not return the captured upper word.");
	a_word1_whole: assert property (
		sel && hit(i_mgmt_regad, anp_pkg::OFFSET_WORD1) |=>
		o_mgmt_rdata == $past(page[15:0]))
		else $error("Word one differs from page D15 to D0.");
	a_resolved_track: assert property (
		1'b1 |=> state.resolved == $past({i_resolved_10g_with_fec, i_resolved_10g_backplane,
			i_resolved_1g_backplane}))
		else $error("Resolved mode was not registered from the inputs.");
	a_result_gap_zero: assert property (
		sel && hit(i_mgmt_regad, anp_pkg::OFFSET_RESULT) |=>
		!o_mgmt_rdata[2])
		else $error("Result register bit 2 is not zero.");
endmodule

// ### bench/anp_link_partner.sv
// Behavioural link partner that delivers received pages and the resolved mode.
`timescale 1ns/1ns
module anp_link_partner (
	input wire logic i_core_clk,
	input wire logic i_send,
	input wire logic [47:0] i_word,
	input wire logic [2:0] i_mode,
	output logic o_page_valid,
	output logic [47:0] o_page,
	output logic [2:0] o_mode
);
	// Outside a delivery the page lines show the inverse of the last value.
	always_ff @(posedge i_core_clk) begin
		o_page_valid <= i_send;
		o_page <= i_send ? i_word : ~o_page;
		o_mode <= i_mode;
	end
endmodule

// ### bench/autoneg_partner_next_page_status_test.sv
// Self-checking bench for the partner next page status registers.
`timescale 1ns/1ns
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin fails++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module autoneg_partner_next_page_status_test;
	logic clk, nrst, send, rd, wr, pv, rv;
	logic [2:0] mode, mq;
	logic [47:0] word, pg;
	logic [4:0] devad;
	logic [15:0] regad, wdata, rdata;
	logic [15:0] res [3] = '{16'h0003, 16'h0009, 16'h0011};
	logic [47:0] p1 = 48'h1357_2468_a5c3;
	logic [47:0] p2 = 48'heca8_db97_5a3c;
	int fails = 0;
	int n_tests = 0;
	int cyc = 0;
	anp_link_partner lp (.i_core_clk(clk), .i_send(send), .i_word(word), .i_mode(mode),
		.o_page_valid(pv), .o_page(pg), .o_mode(mq));
	anp_status_regs dut (.i_core_clk(clk), .i_nrst(nrst), .i_page_valid(pv), .i_page(pg),
		.i_resolved_10g_with_fec(mq[2]), .i_resolved_10g_backplane(mq[1]),
		.i_resolved_1g_backplane(mq[0]), .i_mgmt_devad(devad), .i_mgmt_regad(regad),
		.i_mgmt_rd(rd), .i_mgmt_wr(wr), .i_mgmt_wdata(wdata), .o_mgmt_rdata(rdata),
		.o_mgmt_rvalid(rv));
	task automatic end_of_test();
		if (fails == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic acc(input logic [4:0] d, input logic [15:0] a, input logic w,
		input logic [15:0] e, input logic ev);
		@(posedge clk);
		devad <= d; regad <= a; rd <= !w; wr <= w; wdata <= 16'hffff;
		@(posedge clk);
		rd <= 1'b0; wr <= 1'b0;
		#1;
		`CHK("rvalid", ev, rv)
		`CHK("rdata", e, rdata)
	endtask
	task automatic burst(input logic [47:0] p);
		logic [15:0] adr [4];
		logic [15:0] want [4];
		adr = '{16'h0019, 16'h001a, 16'h0019, 16'h001b};
		want = '{p[15:0], p[31:16], p[15:0], p[47:32]};
		@(posedge clk);
		devad <= 5'h07;
		regad <= adr[0];
		wr <= 1'b0;
		rd <= 1'b1;
		for (int i = 1; i <= 4; i++) begin
			@(posedge clk);
			if (i < 4) begin
				regad <= adr[i];
			end else begin
				rd <= 1'b0;
			end
			#1;
			`CHK("burst rvalid", 1'b1, rv)
			`CHK("burst rdata", want[i - 1], rdata)
		end
	endtask
	task automatic page(input logic [47:0] p);
		@(posedge clk);
		send <= 1'b1; word <= p;
		@(posedge clk);
		send <= 1'b0;
		@(posedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			end_of_test();
		end
	end
	initial begin
		nrst = 1'b0; send = 1'b0; rd = 1'b0; wr = 1'b0; mode = 3'h0; word = 48'h0;
		devad = 5'h00; regad = 16'h0000; wdata = 16'h0000;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		acc(5'h07, 16'h001a, 1'b0, 16'h0000, 1'b1);
		acc(5'h07, 16'h0019, 1'b0, 16'h0000, 1'b1);
		acc(5'h07, 16'h0030, 1'b0, 16'h0001, 1'b1);
		page(p1);
		acc(5'h07, 16'h0019, 1'b0, p1[15:0], 1'b1);
		page(p2);
		acc(5'h07, 16'h001a, 1'b0, p1[31:16], 1'b1);
		acc(5'h07, 16'h001b, 1'b0, p1[47:32], 1'b1);
		acc(5'h07, 16'h0019, 1'b0, p2[15:0], 1'b1);
		acc(5'h07, 16'h001a, 1'b0, p2[31:16], 1'b1);
		acc(5'h07, 16'h001b, 1'b0, p2[47:32], 1'b1);
		burst(p2);
		acc(5'h07, 16'h0019, 1'b1, p2[47:32], 1'b0);
		acc(5'h07, 16'h0019, 1'b0, p2[15:0], 1'b1);
		acc(5'h1e, 16'h0019, 1'b0, p2[15:0], 1'b0);
		acc(5'h07, 16'h0020, 1'b0, 16'h0000, 1'b1);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk) mode <= 3'h1 << i;
			repeat (3) @(posedge clk);
			acc(5'h07, 16'h0030, 1'b0, res[i], 1'b1);
		end
		@(posedge clk);
		mode <= 3'h0;
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		acc(5'h07, 16'h001a, 1'b0, 16'h0000, 1'b1);
		acc(5'h07, 16'h001b, 1'b0, 16'h0000, 1'b1);
		acc(5'h07, 16'h0019, 1'b0, 16'h0000, 1'b1);
		acc(5'h07, 16'h0030, 1'b0, 16'h0001, 1'b1);
		end_of_test();
	end
endmodule
